// ===== logic/dpa_acquisition.sv
// top of the distance position acquisition block
// assumes frames already deframed upstream, one pulse per frame
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
module dpa_acquisition
   import dpa_pkg::*;
#(
   parameter int TICK_CYCLES = DPA_TICK_CYCLES
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   // serial-terminal frame stream
   input  wire logic        ser_header,
   input  wire logic        ser_valid,
   input  wire logic        ser_invalid,
   input  wire logic [15:0] ser_protocol,
   input  wire logic [31:0] ser_distance,
   // network frame stream
   input  wire logic        net_valid,
   input  wire logic        net_invalid,
   input  wire logic [31:0] net_distance,
   // option card encoder stream
   input  wire logic        enc_valid,
   input  wire logic        enc_invalid,
   input  wire logic [23:0] enc_count,
   // applied communication settings
   output logic [15:0]      active_protocol,
   output logic [15:0]      active_baud_hundreds,
   output logic             active_two_stop,
   output logic             active_seven_data,
   output logic [15:0]      active_parity,
   // results
   output logic [31:0]      position,
   output logic             meter_fault
);
   // ==========================================================
   // software settings
   // comm settings load at power-up only
   logic [15:0] protocol_select_reg = DPA_RST_PROTOCOL;
   logic [15:0] serial_speed_setting_reg = DPA_RST_SPEED;
   logic [15:0] stop_data_length_setting_reg = DPA_RST_STOPDATA;
   logic [15:0] parity_setting_reg = DPA_RST_PARITY;
   logic [15:0] retry_limit_reg;
   logic [15:0] serial_check_interval_reg;
   logic [15:0] meter_source_select_reg;
   logic [15:0] distance_unit_select_reg;
   logic [15:0] travel_per_revolution_reg;
   logic [15:0] measurement_fault_interval_reg;
   logic [15:0] zero_count_upper_reg;
   logic [15:0] zero_count_lower_reg;
   logic [15:0] zero_calibration_control_reg;
   logic [15:0] lower_limit_reg;
   logic [15:0] upper_limit_reg;
   logic        test_op_reg;
   logic [15:0] reg_rdata_reg;
   logic        applied_reg;
   logic [15:0] retry_count_reg;
   logic        meter_fault_reg;
   logic [31:0] position_reg;
   logic [23:0] zero_cap_reg;
   logic [23:0] tick_div_reg;
   logic        tick_reg;
   dpa_zc_state_t zc_state_reg;
   dpa_zc_state_t zc_state_next;

   wire wr_hit_zctrl = reg_wr && (reg_addr == DPA_OFS_ZCTRL);
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // comm settings survive reset
         retry_limit_reg                <= DPA_RST_RETRY;
         serial_check_interval_reg      <= DPA_RST_CHECK;
         meter_source_select_reg        <= DPA_RST_SOURCE;
         distance_unit_select_reg       <= DPA_RST_UNIT;
         travel_per_revolution_reg      <= DPA_RST_TRAVEL;
         measurement_fault_interval_reg <= DPA_RST_MEASFLT;
         lower_limit_reg                <= 16'h0000;
         upper_limit_reg                <= 16'h0000;
         test_op_reg                    <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            DPA_OFS_PROTOCOL: protocol_select_reg          <= reg_wdata;
            DPA_OFS_SPEED:    serial_speed_setting_reg     <= reg_wdata;
            DPA_OFS_STOPDATA: stop_data_length_setting_reg <= reg_wdata;
            DPA_OFS_PARITY:   parity_setting_reg           <= reg_wdata;
            DPA_OFS_RETRY:    retry_limit_reg              <= reg_wdata;
            DPA_OFS_CHECK:    serial_check_interval_reg    <= reg_wdata;
            DPA_OFS_SOURCE:   meter_source_select_reg      <= reg_wdata;
            DPA_OFS_UNIT:     distance_unit_select_reg     <= reg_wdata;
            DPA_OFS_TRAVEL:   travel_per_revolution_reg    <= reg_wdata;
            DPA_OFS_MEASFLT:  measurement_fault_interval_reg <= reg_wdata;
            DPA_OFS_LOWLIM:   lower_limit_reg              <= reg_wdata;
            DPA_OFS_UPLIM:    upper_limit_reg              <= reg_wdata;
            DPA_OFS_TESTOP:   test_op_reg                  <= reg_wdata[0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // communication settings latched once after reset release
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         applied_reg          <= 1'b0;
         active_protocol      <= 16'h0000;
         active_baud_hundreds <= 16'h0000;
         active_two_stop      <= 1'b0;
         active_seven_data    <= 1'b0;
         active_parity        <= 16'h0000;
      end else if (!applied_reg) begin
         applied_reg          <= 1'b1;
         active_protocol      <= protocol_select_reg;
         active_baud_hundreds <= serial_speed_setting_reg;
         active_two_stop      <= (stop_data_length_setting_reg ==
                                  DPA_STOPDATA_2S7D);
         active_seven_data    <= (stop_data_length_setting_reg ==
                                  DPA_STOPDATA_2S7D);
         active_parity        <= parity_setting_reg;
      end
   end

   // ==========================================================
   // source selection
   wire from_ser = (meter_source_select_reg == DPA_SRC_SERIAL);
   wire from_net = (meter_source_select_reg == DPA_SRC_NETWORK);
   wire from_enc = (meter_source_select_reg == DPA_SRC_OPTION);
   // a frame decoded under another protocol counts as invalid
   wire ser_match = (ser_protocol == active_protocol);
   wire sel_valid = (from_ser && ser_valid && ser_match) ||
                    (from_net && net_valid) ||
                    (from_enc && enc_valid);
   wire sel_invalid = (from_ser && (ser_invalid ||
                                    (ser_valid && !ser_match))) ||
                      (from_net && net_invalid) ||
                      (from_enc && enc_invalid);
   wire sel_header = from_ser ? (ser_header && ser_match) : sel_valid;

   // ==========================================================
   // 0.1 s tick divider
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tick_div_reg <= 24'h00_0000;
         tick_reg     <= 1'b0;
      end else if (tick_div_reg == 24'(TICK_CYCLES - 1)) begin
         tick_div_reg <= 24'h00_0000;
         tick_reg     <= 1'b1;
      end else begin
         tick_div_reg <= tick_div_reg + 24'h00_0001;
         tick_reg     <= 1'b0;
      end
   end

   logic header_lost;
   logic data_lost;
   dpa_interval_timer #(.WIDTH(16)) u_header_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .tick    (tick_reg),
      .restart (sel_header),
      .limit   (serial_check_interval_reg),
      .expired (header_lost)
   );
   dpa_interval_timer #(.WIDTH(16)) u_data_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .tick    (tick_reg),
      .restart (sel_valid),
      .limit   (measurement_fault_interval_reg),
      .expired (data_lost)
   );

   // ==========================================================
   // retry count and latched fault
   wire retry_on   = (retry_limit_reg != DPA_DISABLE_CODE);
   wire retry_over = retry_on && (retry_count_reg > retry_limit_reg);
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         retry_count_reg <= 16'h0000;
      end else if (sel_valid) begin
         retry_count_reg <= 16'h0000;
      end else if (sel_invalid && retry_count_reg != 16'hffff) begin
         retry_count_reg <= retry_count_reg + 16'h0001;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meter_fault_reg <= 1'b0;
      end else if (retry_over || header_lost || data_lost) begin
         meter_fault_reg <= 1'b1;
      end
   end
   assign meter_fault = meter_fault_reg;

   // ==========================================================
   // encoder range arithmetic, 0.1 mm units
   // travel is in 0.01 mm, so steps*travel/10 gives 0.1 mm
   wire [47:0] full_range = 48'(travel_per_revolution_reg) *
                            48'(DPA_TURN_STEPS) / 48'd10;
   wire [47:0] span       = 48'(upper_limit_reg - lower_limit_reg) *
                            48'(DPA_SPAN_SCALE) / 48'd100;
   wire [47:0] margin     = (full_range > span) ?
                            ((full_range - span) >> 1) : 48'h0;
   wire [47:0] low_base   = 48'(lower_limit_reg) * 48'd10;
   wire [47:0] meas_lo    = (low_base > margin) ?
                            (low_base - margin) : 48'h0;
   wire [47:0] meas_hi    = 48'(upper_limit_reg) * 48'd10 + margin;
   wire [23:0] zero_cap   = {zero_count_upper_reg[7:0],
                             zero_count_lower_reg};
   wire [23:0] rel_count  = enc_count - zero_cap;
   // per count: travel / (4096 steps * 10)
   wire [47:0] enc_dist   = meas_lo + 48'(rel_count) *
                            48'(travel_per_revolution_reg) / 48'd40960;
   wire [47:0] enc_mapped = (enc_dist > meas_hi) ? meas_lo :
                            (enc_dist < meas_lo) ? meas_hi :
                            enc_dist;

   // ==========================================================
   // laser scaling and clamp
   wire [31:0] laser_raw  = from_ser ? ser_distance : net_distance;
   wire [47:0] laser_dist = (distance_unit_select_reg == 16'h0000) ?
                            48'(laser_raw) * 48'd10 :
                            48'(laser_raw);
   wire [47:0] conv_dist  = from_enc ? enc_mapped : laser_dist;
   wire [31:0] clamped    = (conv_dist > 48'(DPA_POS_MAX)) ?
                            DPA_POS_MAX : conv_dist[31:0];
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         position_reg <= 32'h0000_0000;
      end else if (sel_valid) begin
         position_reg <= clamped;
      end
   end
   assign position = position_reg;

   // ==========================================================
   // zero calibration sequencer
   wire comm_ok   = from_enc && applied_reg &&
                    (active_protocol == protocol_select_reg);
   wire count_ok  = (enc_count != DPA_ENC_MAX) &&
                    (full_range > span);
   always_comb begin
      zc_state_next = zc_state_reg;
      case (zc_state_reg)
         DPA_ZC_IDLE: begin
            if (zero_calibration_control_reg == DPA_ZC_START) begin
               zc_state_next = DPA_ZC_CHECK;
            end
         end
         DPA_ZC_CHECK: begin
            if (test_op_reg || !comm_ok || !count_ok) begin
               zc_state_next = DPA_ZC_BAD;
            end else if (enc_valid) begin
               zc_state_next = DPA_ZC_OK;
            end
         end
         DPA_ZC_OK:  zc_state_next = DPA_ZC_IDLE;
         DPA_ZC_BAD: zc_state_next = DPA_ZC_IDLE;
         default:    zc_state_next = DPA_ZC_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         zc_state_reg <= DPA_ZC_IDLE;
         zero_cap_reg <= 24'h00_0000;
      end else begin
         zc_state_reg <= zc_state_next;
         if (zc_state_reg == DPA_ZC_CHECK && enc_valid) begin
            zero_cap_reg <= enc_count;
         end
      end
   end
   // calibration result overrides a software write in the same cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         zero_calibration_control_reg <= DPA_ZC_OFF;
         zero_count_upper_reg         <= 16'h0000;
         zero_count_lower_reg         <= 16'h0000;
      end else if (zc_state_reg == DPA_ZC_OK) begin
         zero_calibration_control_reg <= DPA_ZC_DONE;
         zero_count_upper_reg <= {8'h00, zero_cap_reg[23:16]};
         zero_count_lower_reg <= zero_cap_reg[15:0];
      end else if (zc_state_reg == DPA_ZC_BAD) begin
         zero_calibration_control_reg <= DPA_ZC_FAIL;
      end else begin
         if (wr_hit_zctrl && zc_state_reg == DPA_ZC_IDLE) begin
            zero_calibration_control_reg <= reg_wdata;
         end
         if (reg_wr && reg_addr == DPA_OFS_ZUPPER) begin
            zero_count_upper_reg <= {8'h00, reg_wdata[7:0]};
         end
         if (reg_wr && reg_addr == DPA_OFS_ZLOWER) begin
            zero_count_lower_reg <= reg_wdata;
         end
      end
   end

   // ==========================================================
   // read port
   logic [15:0] rd_mux;
   always_comb begin
      case (reg_addr)
         DPA_OFS_PROTOCOL: rd_mux = protocol_select_reg;
         DPA_OFS_SPEED:    rd_mux = serial_speed_setting_reg;
         DPA_OFS_STOPDATA: rd_mux = stop_data_length_setting_reg;
         DPA_OFS_PARITY:   rd_mux = parity_setting_reg;
         DPA_OFS_RETRY:    rd_mux = retry_limit_reg;
         DPA_OFS_CHECK:    rd_mux = serial_check_interval_reg;
         DPA_OFS_SOURCE:   rd_mux = meter_source_select_reg;
         DPA_OFS_UNIT:     rd_mux = distance_unit_select_reg;
         DPA_OFS_TRAVEL:   rd_mux = travel_per_revolution_reg;
         DPA_OFS_MEASFLT:  rd_mux = measurement_fault_interval_reg;
         DPA_OFS_ZUPPER:   rd_mux = zero_count_upper_reg;
         DPA_OFS_ZLOWER:   rd_mux = zero_count_lower_reg;
         DPA_OFS_ZCTRL:    rd_mux = zero_calibration_control_reg;
         DPA_OFS_LOWLIM:   rd_mux = lower_limit_reg;
         DPA_OFS_UPLIM:    rd_mux = upper_limit_reg;
         DPA_OFS_TESTOP:   rd_mux = {15'h0000, test_op_reg};
         DPA_OFS_STATUS:   rd_mux = {12'h000, data_lost, header_lost,
                                     retry_over, meter_fault_reg};
         DPA_OFS_POSITION: rd_mux = position_reg[15:0];
         DPA_OFS_RETRYCNT: rd_mux = retry_count_reg;
         default:          rd_mux = 16'h0000;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata_reg <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata_reg <= rd_mux;
      end else begin
         reg_rdata_reg <= 16'h0000;
      end
   end
   assign reg_rdata = reg_rdata_reg;
endmodule

// ===== include/dpa_pkg.sv
// constants and types for the distance position acquisition block
// assumes a 10 MHz ref_clk and software-held settings in strobed registers
package dpa_pkg;
   // ==========================================================
   // register offsets
   localparam logic [4:0] DPA_OFS_PROTOCOL   = 5'h00;
   localparam logic [4:0] DPA_OFS_SPEED      = 5'h01;
   localparam logic [4:0] DPA_OFS_STOPDATA   = 5'h02;
   localparam logic [4:0] DPA_OFS_PARITY     = 5'h03;
   localparam logic [4:0] DPA_OFS_RETRY      = 5'h04;
   localparam logic [4:0] DPA_OFS_CHECK      = 5'h05;
   localparam logic [4:0] DPA_OFS_SOURCE     = 5'h06;
   localparam logic [4:0] DPA_OFS_UNIT       = 5'h07;
   localparam logic [4:0] DPA_OFS_TRAVEL     = 5'h08;
   localparam logic [4:0] DPA_OFS_MEASFLT    = 5'h09;
   localparam logic [4:0] DPA_OFS_ZUPPER     = 5'h0a;
   localparam logic [4:0] DPA_OFS_ZLOWER     = 5'h0b;
   localparam logic [4:0] DPA_OFS_ZCTRL      = 5'h0c;
   localparam logic [4:0] DPA_OFS_LOWLIM     = 5'h0d;
   localparam logic [4:0] DPA_OFS_UPLIM      = 5'h0e;
   localparam logic [4:0] DPA_OFS_TESTOP     = 5'h0f;
   localparam logic [4:0] DPA_OFS_STATUS     = 5'h10;
   localparam logic [4:0] DPA_OFS_POSITION   = 5'h11;
   localparam logic [4:0] DPA_OFS_RETRYCNT   = 5'h12;
   // ==========================================================
   // power-up and reset values
   localparam logic [15:0] DPA_RST_PROTOCOL  = 16'h0000;
   localparam logic [15:0] DPA_RST_SPEED     = 16'h00c0;
   localparam logic [15:0] DPA_RST_STOPDATA  = 16'h0000;
   localparam logic [15:0] DPA_RST_PARITY    = 16'h0002;
   localparam logic [15:0] DPA_RST_RETRY     = 16'h0001;
   localparam logic [15:0] DPA_RST_CHECK     = 16'h0000;
   localparam logic [15:0] DPA_RST_SOURCE    = 16'h0000;
   localparam logic [15:0] DPA_RST_UNIT      = 16'h0001;
   localparam logic [15:0] DPA_RST_TRAVEL    = 16'h2710;
   localparam logic [15:0] DPA_RST_MEASFLT   = 16'h0000;
   // ==========================================================
   // setting codes
   localparam logic [15:0] DPA_DISABLE_CODE  = 16'h270f;
   localparam logic [15:0] DPA_ZC_OFF        = 16'h0000;
   localparam logic [15:0] DPA_ZC_START      = 16'h0001;
   localparam logic [15:0] DPA_ZC_DONE       = 16'h0003;
   localparam logic [15:0] DPA_ZC_FAIL       = 16'h0009;
   localparam logic [15:0] DPA_SRC_SERIAL    = 16'h0000;
   localparam logic [15:0] DPA_SRC_NETWORK   = 16'h0001;
   localparam logic [15:0] DPA_SRC_OPTION    = 16'h0002;
   localparam logic [15:0] DPA_PROTO_MODBUS  = 16'h0001;
   localparam logic [15:0] DPA_STOPDATA_2S7D = 16'h000b;
   localparam logic [15:0] DPA_SPEED_DIV     = 16'h0064;
   // ==========================================================
   // geometry, 0.1 mm units
   localparam logic [31:0] DPA_POS_MAX       = 32'h002d_c6c0;
   localparam logic [31:0] DPA_SPAN_SCALE    = 32'h0000_03e8;
   localparam logic [31:0] DPA_TURN_STEPS    = 32'h0000_1000;
   localparam logic [23:0] DPA_ENC_MAX       = 24'hff_ffff;
   // ==========================================================
   // timing: intervals in 0.1 s, 10 MHz clock
   localparam int DPA_CLK_HZ                 = 10_000_000;
   localparam int DPA_TICK_MS                = 100;
   localparam int DPA_TICK_CYCLES = DPA_CLK_HZ / 1000 * DPA_TICK_MS;
   // ==========================================================
   typedef enum logic [3:0] {
      DPA_ZC_IDLE  = 4'b0001,
      DPA_ZC_CHECK = 4'b0010,
      DPA_ZC_OK    = 4'b0100,
      DPA_ZC_BAD   = 4'b1000
   } dpa_zc_state_t;
endpackage

// ===== logic/dpa_interval_timer.sv
// supervision timer: counts ticks since last restart
// assumes tick is a one-cycle enable from the 0.1 s divider
`timescale 1ns/10ps
module dpa_interval_timer
   import dpa_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset,
   // control
   input  wire logic             tick,
   input  wire logic             restart,
   input  wire logic [WIDTH-1:0] limit,
   // result
   output logic                  expired
);
   logic [WIDTH-1:0] count_reg;
   wire              enabled = (limit != DPA_DISABLE_CODE[WIDTH-1:0]) &&
                               (limit != '0);
   wire              at_limit = (count_reg >= limit);
   always_ff @(posedge ref_clk) begin
      if (reset || restart) begin
         count_reg <= '0;
      end else if (tick && !at_limit) begin
         count_reg <= count_reg + 1'b1;
      end
   end
   assign expired = enabled && at_limit;
endmodule

// ===== test/dpa_acquisition_monitor.sv
// port checker for the acquisition top
// assumes it is bound into dpa_acquisition
`timescale 1ns/10ps
module dpa_acquisition_monitor
   import dpa_pkg::*;
#(
   parameter int TICK_CYCLES = 10
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset,
   // register port
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // streams
   input wire logic        ser_valid,
   input wire logic        net_valid,
   input wire logic        enc_valid,
   // results
   input wire logic [15:0] active_protocol,
   input wire logic [15:0] active_baud_hundreds,
   input wire logic        active_two_stop,
   input wire logic        active_seven_data,
   input wire logic [15:0] active_parity,
   input wire logic [31:0] position,
   input wire logic        meter_fault
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // properties
   property p_rd_one;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   property p_latch;
      meter_fault |=> meter_fault [*3];
   endproperty
   property p_proto_hold;
      !$past(reset) && !$past(reset, 2) |->
         $stable(active_protocol) && $stable(active_baud_hundreds);
   endproperty
   property p_line_hold;
      !$past(reset) && !$past(reset, 2) |-> $stable(active_parity)
         && $stable(active_two_stop) && $stable(active_seven_data);
   endproperty
   property p_pos_cause;
      position != $past(position) |->
         $past(ser_valid || net_valid || enc_valid);
   endproperty
   property p_pos_max;
      position <= DPA_POS_MAX;
   endproperty
   property p_rst_out;
      disable iff (1'b0) reset |=>
         position == 32'h0000_0000 && !meter_fault;
   endproperty
   property p_rst_act;
      disable iff (1'b0) reset |=> active_protocol == 16'h0000
         && active_baud_hundreds == 16'h0000 && !active_two_stop;
   endproperty
   // ==========================================================
   // assertions
   a_rd_one: assert property (p_rd_one)
      else $error("read data outside read answer cycle");
   a_latch: assert property (p_latch)
      else $error("meter fault dropped");
   a_proto_hold: assert property (p_proto_hold)
      else $error("active protocol or speed changed");
   a_line_hold: assert property (p_line_hold)
      else $error("active framing changed");
   a_pos_cause: assert property (p_pos_cause)
      else $error("position changed without data");
   a_pos_max: assert property (p_pos_max)
      else $error("position above limit");
   a_rst_out: assert property (p_rst_out)
      else $error("outputs not cleared by reset");
   a_rst_act: assert property (p_rst_act)
      else $error("active settings not cleared by reset");
   c_fault: cover property ($rose(meter_fault));
   c_pos: cover property (position != $past(position));
   c_read: cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule
bind dpa_acquisition dpa_acquisition_monitor #(
   .TICK_CYCLES(TICK_CYCLES)
) u_mon (.ref_clk, .reset, .reg_rd, .reg_rdata, .ser_valid, .net_valid,
   .enc_valid, .active_protocol, .active_baud_hundreds, .active_two_stop,
   .active_seven_data, .active_parity, .position, .meter_fault);

// ===== test/dpa_sensor_model.sv
// sensor stand-in: deframed serial pulses and encoder counts
// assumes tasks are called by the bench
`timescale 1ns/10ps
module dpa_sensor_model (
   // clock
   input  wire logic   ref_clk,
   // serial frames
   output logic        ser_header,
   output logic        ser_valid,
   output logic        ser_invalid,
   output logic [15:0] ser_protocol,
   output logic [31:0] ser_distance,
   // encoder
   output logic        enc_valid,
   output logic [23:0] enc_count
);
   initial begin
      {ser_header, ser_valid, ser_invalid, enc_valid} = 4'h0;
      ser_protocol = 16'h0000;
      ser_distance = 32'h0000_0000;
      enc_count = 24'h00_0000;
   end
   // released data lines show the inverse of the last value
   task frame(input logic ok, input logic [15:0] pr, input logic [31:0] d);
      @(posedge ref_clk);
      ser_header <= 1'b1;
      ser_valid <= ok;
      ser_invalid <= !ok;
      ser_protocol <= pr;
      ser_distance <= d;
      @(posedge ref_clk);
      {ser_header, ser_valid, ser_invalid} <= 3'h0;
      ser_protocol <= ~pr;
      ser_distance <= ~d;
   endtask
   task enc(input logic [23:0] c);
      @(posedge ref_clk);
      enc_valid <= 1'b1;
      enc_count <= c;
      @(posedge ref_clk);
      enc_valid <= 1'b0;
      enc_count <= ~c;
   endtask
endmodule

// ===== test/tb_dpa_acquisition.sv
// self-checking bench for dpa_acquisition
// assumes TICK_CYCLES shortened to 10
`timescale 1ns/10ps
module tb_dpa_acquisition import dpa_pkg::*; ;
   logic        ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [4:0]  reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, v, ser_protocol;
   logic [15:0] active_protocol, active_baud_hundreds, active_parity;
   logic        ser_header, ser_valid, ser_invalid, enc_valid;
   logic        active_two_stop, active_seven_data, meter_fault;
   logic [31:0] ser_distance, position;
   logic [23:0] enc_count;
   logic        enc_invalid = 1'b0;
   int          errors = 0, n_compared = 0;
   initial forever #50 ref_clk = ~ref_clk;
   dpa_sensor_model m (.ref_clk, .ser_header, .ser_valid, .ser_invalid,
      .ser_protocol, .ser_distance, .enc_valid, .enc_count);
   dpa_acquisition #(.TICK_CYCLES(10)) uut (.ref_clk, .reset, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ser_header, .ser_valid,
      .ser_invalid, .ser_protocol, .ser_distance, .net_valid(1'b0),
      .net_invalid(1'b0), .net_distance(32'h0000_0000), .enc_valid,
      .enc_invalid, .enc_count, .active_protocol,
      .active_baud_hundreds, .active_two_stop, .active_seven_data,
      .active_parity, .position, .meter_fault);
   // ==========================================================
   // shared tasks
   task end_of_test;
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      n_compared++;
      if (seen !== ex) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [4:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task settle;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task do_reset;
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      settle();
   endtask
   task poll_zc;
      for (int i = 0; i < 20; i++) begin
         m.enc(24'h12_3456);
         rd(DPA_OFS_ZCTRL);
         if (v !== DPA_ZC_START) return;
      end
      errors++;
      end_of_test();
   endtask
   // ==========================================================
   // scenarios
   task t_defaults;
      rd(DPA_OFS_SPEED); chk("speed", v, 16'h00c0);
      rd(DPA_OFS_PARITY); chk("parity", v, 16'h0002);
      rd(DPA_OFS_RETRY); chk("retry", v, 16'h0001);
      rd(DPA_OFS_SOURCE); chk("source", v, DPA_SRC_SERIAL);
      rd(DPA_OFS_UNIT); chk("unit", v, 16'h0001);
      rd(DPA_OFS_ZCTRL); chk("zctrl", v, DPA_ZC_OFF);
      wr(5'h1f, 16'hffff);
      rd(5'h1f); chk("unmapped", v, 16'h0000);
   endtask
   task t_comm_reset;
      wr(DPA_OFS_SPEED, 16'h0180);
      wr(DPA_OFS_STOPDATA, DPA_STOPDATA_2S7D);
      wr(DPA_OFS_PARITY, 16'h0000);
      settle(); chk("baud held", active_baud_hundreds, 16'h00c0);
      do_reset(); chk("baud", active_baud_hundreds, 16'h0180);
      chk("two stop", active_two_stop, 1'b1);
      chk("seven data", active_seven_data, 1'b1);
      chk("parity", active_parity, 16'h0000);
   endtask
   task t_scale;
      m.frame(1'b1, 16'h0000, 32'd100);
      settle(); chk("pos 0.1mm", position, 32'd100);
      wr(DPA_OFS_UNIT, 16'h0000);
      m.frame(1'b1, 16'h0000, 32'd100);
      settle(); chk("pos 1mm", position, 32'd1000);
      m.frame(1'b1, 16'h0000, 32'h0010_0000);
      settle(); chk("pos clamp", position, DPA_POS_MAX);
   endtask
   task t_retry;
      wr(DPA_OFS_RETRY, DPA_DISABLE_CODE);
      repeat (4) m.frame(1'b0, 16'h0000, 32'd0);
      settle(); chk("fault off", meter_fault, 1'b0);
      m.frame(1'b1, 16'h0000, 32'd5);
      wr(DPA_OFS_RETRY, 16'h0001);
      m.frame(1'b0, 16'h0000, 32'd0);
      settle(); chk("fault at limit", meter_fault, 1'b0);
      m.frame(1'b1, 16'h0001, 32'd5);
      settle(); chk("fault over", meter_fault, 1'b1);
      m.frame(1'b1, 16'h0000, 32'd5);
      settle(); chk("fault held", meter_fault, 1'b1);
      do_reset(); chk("fault reset", meter_fault, 1'b0);
   endtask
   // ranges left at reset values keep the span inside the encoder range
   task t_zero;
      wr(DPA_OFS_ZCTRL, DPA_ZC_START);
      poll_zc(); chk("zc fail", v, DPA_ZC_FAIL);
      rd(DPA_OFS_ZUPPER); chk("zu kept", v, 16'h0000);
      rd(DPA_OFS_ZLOWER); chk("zl kept", v, 16'h0000);
      wr(DPA_OFS_SOURCE, DPA_SRC_OPTION);
      wr(DPA_OFS_ZCTRL, DPA_ZC_START);
      poll_zc(); chk("zc done", v, DPA_ZC_DONE);
      rd(DPA_OFS_ZUPPER); chk("zu", v, 16'h0012);
      rd(DPA_OFS_ZLOWER); chk("zl", v, 16'h3456);
      m.enc(24'h12_3456);
      settle(); chk("pos zero", position, 32'd0);
      @(posedge ref_clk) enc_invalid <= 1'b1;
      @(posedge ref_clk) enc_invalid <= 1'b0;
      rd(DPA_OFS_RETRYCNT); chk("retry enc", v, 16'h0001);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      settle();
      t_defaults();
      t_comm_reset();
      t_scale();
      t_retry();
      t_zero();
      end_of_test();
   end
endmodule
